// [core/sac_core.sv]
`default_nettype none
module sac_core
    import sac_pkg::*;
#(
    parameter int unsigned CAL_PERIODS  = SAC_CAL_PERIODS,
    parameter int unsigned SETTLE_WORDS = SAC_SETTLE_WORDS
) (
    input  wire logic      CLK_SYS,
    input  wire logic      ARST_N,
    input  wire logic      DIGITAL_SLEEP_IN,
    input  wire logic      ANALOG_SLEEP_IN,
    input  wire logic      CLOCK_RATIO_SELECT,
    input  wire logic      SERIAL_ROLE_SELECT,
    input  wire logic      ZERO_INPUT_SELECT,
    input  wire sac_pair_s SAMPLE_PAIR,
    input  wire logic      SAMPLE_VALID,
    input  wire logic      BIT_CLOCK_I,
    output logic           BIT_CLOCK_O,
    output logic           BIT_CLOCK_OE,
    input  wire logic      CHANNEL_STROBE_I,
    output logic           CHANNEL_STROBE_O,
    output logic           CHANNEL_STROBE_OE,
    input  wire logic      DATA_WINDOW_I,
    output logic           DATA_WINDOW_O,
    output logic           DATA_WINDOW_OE,
    output logic           SERIAL_OUT_LINE,
    output logic           MODULATOR_CLOCK_OUT,
    output logic           CALIBRATING_FLAG,
    output logic           CAL_INPUT_GROUND,
    output logic           WORDS_SETTLING,
    output logic           ANALOG_POWERDOWN,
    output logic           DIGITAL_POWERDOWN
);
    localparam int unsigned CW = $clog2(CAL_PERIODS);

    logic [SAC_PIN_N-1:0] pins_s1_q;
    logic [SAC_PIN_N-1:0] pins_s2_q;
    logic                 lr_s3_q;
    logic                 bc_s3_q;
    sac_state_e           state_q;
    sac_state_e           state_d;
    logic                 role_q;
    logic                 ratio_q;
    logic                 active;
    logic [2:0]           half;
    logic [2:0]           div_cnt_q;
    logic [2:0]           div_cnt_d;
    logic                 fall_tick;
    logic [5:0]           bit_cnt_q;
    logic [5:0]           nxt;
    logic                 strobe_q;
    logic                 bclk_q;
    logic                 dw_q;
    logic                 lr_edge;
    logic                 bc_fall;
    logic                 strobe_rise;
    logic                 load_evt;
    logic                 load_left;
    logic                 shift_evt;
    logic [CW-1:0]        cnt_q;
    logic                 cal_q;
    logic                 settle_q;
    logic                 gnd_q;
    logic [1:0]           start_cnt_q;
    logic                 rise_seen_q;
    logic                 phase_b_q;
    logic [1:0]           mod_cnt_q;
    logic [1:0]           mod_cnt_d;
    logic                 mod_q;
    sac_pair_s            off_q;
    sac_pair_s            corr_q;
    sac_pair_s            pair_q;
    sac_word_t            sh_q;
    logic [7:0]           win_len_q;

    // Two-flop synchronisers for every pin input
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pins_s1_q <= SAC_PIN_RST;
            pins_s2_q <= SAC_PIN_RST;
            lr_s3_q   <= 1'b0;
            bc_s3_q   <= 1'b0;
        end
        else
        begin
            pins_s1_q <= {DATA_WINDOW_I, CHANNEL_STROBE_I, BIT_CLOCK_I, ZERO_INPUT_SELECT,
                          SERIAL_ROLE_SELECT, CLOCK_RATIO_SELECT, ANALOG_SLEEP_IN,
                          DIGITAL_SLEEP_IN};
            pins_s2_q <= pins_s1_q;
            lr_s3_q   <= pins_s2_q[SAC_P_LR];
            bc_s3_q   <= pins_s2_q[SAC_P_BCLK];
        end
    end

    assign active = (state_q != SAC_SLEEP);
    assign half   = ratio_q ? SAC_HALF_R384 : SAC_HALF_R256;

    // Partner-driven pins in slave role
    assign lr_edge = pins_s2_q[SAC_P_LR] ^ lr_s3_q;
    assign bc_fall = bc_s3_q & ~pins_s2_q[SAC_P_BCLK];

    // Role and ratio are sampled while asleep and frozen while active
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            role_q  <= 1'b0;
            ratio_q <= 1'b0;
        end
        else if (!active)
        begin
            role_q  <= pins_s2_q[SAC_P_ROLE];
            ratio_q <= pins_s2_q[SAC_P_RATIO];
        end
    end

    // Power-down, calibration and settling sequence
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SAC_SLEEP:
                if (!pins_s2_q[SAC_P_DSLEEP])
                    state_d = SAC_CAL;
            SAC_CAL:
                if (strobe_rise && cnt_q == CW'(CAL_PERIODS - 1))
                    state_d = SAC_SETTLE;
            SAC_SETTLE:
                if (strobe_rise && cnt_q == CW'(SETTLE_WORDS - 1))
                    state_d = SAC_RUN;
            SAC_RUN:
                state_d = SAC_RUN;
            default:
                state_d = SAC_SLEEP;
        endcase
        if (pins_s2_q[SAC_P_DSLEEP])
            state_d = SAC_SLEEP;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q  <= SAC_SLEEP;
            cnt_q    <= '0;
            cal_q    <= 1'b0;
            settle_q <= 1'b0;
            gnd_q    <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cal_q    <= (state_d == SAC_CAL);
            settle_q <= (state_d == SAC_SETTLE);
            gnd_q    <= (state_d == SAC_CAL) && pins_s2_q[SAC_P_ZERO];
            if (state_d != state_q)
                cnt_q <= '0;
            else if (strobe_rise)
                cnt_q <= CW'(cnt_q + 1'b1);
        end
    end

    // Bit clock divider and frame counter for master role
    assign fall_tick = active && role_q && (div_cnt_q == half - 3'h1);
    assign nxt       = 6'(bit_cnt_q + 6'h01);

    always_comb
    begin
        div_cnt_d = 3'h0;
        if (active && role_q && div_cnt_q != {half[1:0], 1'b0} - 3'h1)
            div_cnt_d = 3'(div_cnt_q + 3'h1);
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            div_cnt_q <= 3'h0;
            bclk_q    <= 1'b0;
            bit_cnt_q <= SAC_BIT_RST;
            strobe_q  <= 1'b0;
            dw_q      <= 1'b0;
        end
        else if (!active)
        begin
            div_cnt_q <= 3'h0;
            bclk_q    <= 1'b0;
            bit_cnt_q <= SAC_BIT_RST;
            strobe_q  <= 1'b0;
            dw_q      <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            bclk_q    <= role_q && (div_cnt_d < half);
            if (fall_tick)
            begin
                bit_cnt_q <= nxt;
                strobe_q  <= ~nxt[5];
                dw_q      <= (nxt[4:0] >= SAC_DATA_START) && (nxt[4:0] <= SAC_WIN_LAST);
            end
        end
    end

    assign strobe_rise = role_q ? (fall_tick && bit_cnt_q == SAC_BIT_RST)
                                : (pins_s2_q[SAC_P_LR] & ~lr_s3_q);

    // Word load and shift events for both roles
    always_comb
    begin
        if (role_q)
        begin
            load_evt  = fall_tick && (nxt[4:0] == SAC_DATA_START);
            load_left = ~nxt[5];
            shift_evt = fall_tick;
        end
        else
        begin
            load_evt  = active && lr_edge;
            load_left = pins_s2_q[SAC_P_LR];
            shift_evt = active && bc_fall && pins_s2_q[SAC_P_DW];
        end
    end

    // Offset capture and correction
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            off_q  <= '0;
            corr_q <= '0;
        end
        else if (SAMPLE_VALID && state_q == SAC_CAL)
        begin
            off_q <= SAMPLE_PAIR;
        end
        else if (SAMPLE_VALID && active)
        begin
            corr_q.left  <= sac_word_t'(SAMPLE_PAIR.left - off_q.left);
            corr_q.right <= sac_word_t'(SAMPLE_PAIR.right - off_q.right);
        end
    end

    // Shift register; pair is frozen at the left load
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pair_q <= '0;
            sh_q   <= '0;
        end
        else if (!active)
        begin
            sh_q <= '0;
        end
        else if (load_evt)
        begin
            if (load_left)
            begin
                pair_q <= corr_q;
                sh_q   <= corr_q.left;
            end
            else
            begin
                sh_q <= pair_q.right;
            end
        end
        else if (shift_evt)
        begin
            sh_q <= {sh_q[SAC_WORD_W-2:0], 1'b0};
        end
    end

    // Start-up phase choice for divide by three
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            start_cnt_q <= 2'h0;
            rise_seen_q <= 1'b0;
            phase_b_q   <= 1'b0;
        end
        else if (!active)
        begin
            start_cnt_q <= 2'h0;
            rise_seen_q <= 1'b0;
            phase_b_q   <= 1'b0;
        end
        else
        begin
            if (start_cnt_q != 2'h3)
                start_cnt_q <= 2'(start_cnt_q + 2'h1);
            rise_seen_q <= rise_seen_q | strobe_rise;
            if (start_cnt_q == SAC_ALIGN_EDGE - 2'h1)
                phase_b_q <= ~(rise_seen_q | strobe_rise);
        end
    end

    // Modulator clock divider
    always_comb
    begin
        mod_cnt_d = 2'h0;
        if (active)
        begin
            if (!ratio_q)
                mod_cnt_d = {1'b0, ~mod_cnt_q[0]};
            else if (mod_cnt_q != SAC_DIV3_LAST)
                mod_cnt_d = 2'(mod_cnt_q + 2'h1);
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mod_cnt_q <= 2'h0;
            mod_q     <= 1'b0;
        end
        else
        begin
            mod_cnt_q <= mod_cnt_d;
            mod_q     <= active && (ratio_q ? (mod_cnt_d == {1'b0, phase_b_q})
                                            : mod_cnt_d[0]);
        end
    end

    assign BIT_CLOCK_O         = bclk_q;
    assign BIT_CLOCK_OE        = role_q;
    assign CHANNEL_STROBE_O    = strobe_q;
    assign CHANNEL_STROBE_OE   = role_q;
    assign DATA_WINDOW_O       = dw_q;
    assign DATA_WINDOW_OE      = role_q;
    assign SERIAL_OUT_LINE     = sh_q[SAC_WORD_W-1];
    assign MODULATOR_CLOCK_OUT = mod_q;
    assign CALIBRATING_FLAG    = cal_q;
    assign CAL_INPUT_GROUND    = gnd_q;
    assign WORDS_SETTLING      = settle_q;
    assign ANALOG_POWERDOWN    = pins_s2_q[SAC_P_ASLEEP];
    assign DIGITAL_POWERDOWN   = ~active;

    // Helper: length of each window pulse
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            win_len_q <= 8'h00;
        else if (dw_q)
            win_len_q <= 8'(win_len_q + 8'h01);
        else
            win_len_q <= 8'h00;
    end

    sequence s_div3_low_gap;
        !MODULATOR_CLOCK_OUT ##1 !MODULATOR_CLOCK_OUT ##1 MODULATOR_CLOCK_OUT;
    endsequence

    sequence s_window_after_bit(int n);
        !DATA_WINDOW_O ##n DATA_WINDOW_O;
    endsequence

    a_div2_toggle: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        active && !ratio_q && $past(active) |-> MODULATOR_CLOCK_OUT != $past(MODULATOR_CLOCK_OUT))
        else $error("modulator clock not toggling in divide by two");

    a_div3_period: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N || pins_s2_q[SAC_P_DSLEEP])
        active && ratio_q && start_cnt_q == 2'h3 && $rose(MODULATOR_CLOCK_OUT)
        |=> s_div3_low_gap)
        else $error("modulator clock period not three in divide by three");

    a_win_start_256: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N || pins_s2_q[SAC_P_DSLEEP])
        role_q && !ratio_q && $changed(CHANNEL_STROBE_O) && $past(active)
        |-> s_window_after_bit(4))
        else $error("window not one bit clock after strobe edge");

    a_win_start_384: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N || pins_s2_q[SAC_P_DSLEEP])
        role_q && ratio_q && $changed(CHANNEL_STROBE_O) && $past(active)
        |-> s_window_after_bit(6))
        else $error("window not one bit clock after strobe edge");

    a_window_len: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        role_q && $fell(DATA_WINDOW_O) && active
        |-> win_len_q == (ratio_q ? SAC_WIN_CYC_R384 : SAC_WIN_CYC_R256))
        else $error("window does not span sixteen bits");

    a_cal_flag_start: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        state_q == SAC_SLEEP && !pins_s2_q[SAC_P_DSLEEP] |=> CALIBRATING_FLAG)
        else $error("calibration not started on sleep release");

    a_cal_flag_drop: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        state_q == SAC_CAL && strobe_rise && cnt_q == CW'(CAL_PERIODS - 1)
        && !pins_s2_q[SAC_P_DSLEEP] |=> !CALIBRATING_FLAG ##1 !CALIBRATING_FLAG)
        else $error("calibrating flag not dropped at end");

    a_sleep_hold: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        pins_s2_q[SAC_P_DSLEEP] |=> !CALIBRATING_FLAG && DIGITAL_POWERDOWN
        ##1 bit_cnt_q == SAC_BIT_RST)
        else $error("counters not held during sleep");

    a_slave_hold_msb: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !role_q && active && !pins_s2_q[SAC_P_DW] && !lr_edge |=> $stable(SERIAL_OUT_LINE))
        else $error("serial line moved with window low");
endmodule
`default_nettype wire

// [core/sac_pkg.sv]
`default_nettype none
package sac_pkg;
    localparam int unsigned SAC_WORD_W = 18;
    typedef logic [SAC_WORD_W-1:0] sac_word_t;
    typedef struct packed {
        sac_word_t left;
        sac_word_t right;
    } sac_pair_s;
    typedef enum logic [1:0] {
        SAC_SLEEP  = 2'b00,
        SAC_CAL    = 2'b01,
        SAC_SETTLE = 2'b10,
        SAC_RUN    = 2'b11
    } sac_state_e;
    // Synchroniser lanes
    localparam int unsigned SAC_PIN_N    = 8;
    localparam int unsigned SAC_P_DSLEEP = 0;
    localparam int unsigned SAC_P_ASLEEP = 1;
    localparam int unsigned SAC_P_RATIO  = 2;
    localparam int unsigned SAC_P_ROLE   = 3;
    localparam int unsigned SAC_P_ZERO   = 4;
    localparam int unsigned SAC_P_BCLK   = 5;
    localparam int unsigned SAC_P_LR     = 6;
    localparam int unsigned SAC_P_DW     = 7;
    localparam logic [SAC_PIN_N-1:0] SAC_PIN_RST = 8'h03;
    // Master clocks per bit-clock half period: 256x and 384x word rate
    localparam logic [2:0] SAC_HALF_R256 = 3'h2;
    localparam logic [2:0] SAC_HALF_R384 = 3'h3;
    // Window length in master clocks: 16 bits of 4 or 6 cycles
    localparam logic [7:0] SAC_WIN_CYC_R256 = 8'h40;
    localparam logic [7:0] SAC_WIN_CYC_R384 = 8'h60;
    localparam logic [1:0] SAC_DIV3_LAST    = 2'h2;
    localparam logic [1:0] SAC_ALIGN_EDGE   = 2'h2;
    localparam logic [4:0] SAC_DATA_START   = 5'h01;
    localparam logic [4:0] SAC_WIN_LAST     = 5'h10;
    localparam logic [5:0] SAC_BIT_RST      = 6'h3F;
    localparam int unsigned SAC_CAL_PERIODS  = 4096;
    localparam int unsigned SAC_SETTLE_WORDS = 50;
endpackage
`default_nettype wire

// [verif/sac_core_tb.sv]
`default_nettype none
module sac_core_tb
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned CAL_P = 8;
    localparam int unsigned SET_P = 4;
    localparam sac_pair_s CAL_PAIR = '{left: 18'h00011, right: 18'h3FFF0};
    localparam sac_pair_s DAT_PAIR = '{left: 18'h12345, right: 18'h2ABCD};

    // Ratio, role, zero, gate; mod-clock rises in 24, window cycles, window delay
    typedef struct {logic ra, ro, ze, ga; int mr, wc, dl;} sac_row_s;
    sac_row_s rows [4] = '{
        '{1'b0, 1'b1, 1'b0, 1'b1, 12, 64, 4},
        '{1'b1, 1'b1, 1'b1, 1'b1, 8, 96, 6},
        '{1'b0, 1'b0, 1'b1, 1'b1, 12, 0, 0},
        '{1'b1, 1'b0, 1'b0, 1'b0, 8, 0, 0}
    };

    logic       clk_sys = 1'b0;
    logic       arst_n  = 1'b0;
    logic       dsleep  = 1'b1;
    logic       asleep  = 1'b1;
    logic       ratio   = 1'b0;
    logic       role    = 1'b0;
    logic       zero    = 1'b0;
    logic       gate    = 1'b1;
    logic       svalid  = 1'b0;
    logic       lr_prev = 1'b0;
    logic       m_prev  = 1'b0;
    logic [4:0] scnt    = 5'h00;
    sac_pair_s  spair   = '0;
    sac_pair_s  cur     = '0;
    logic       bclk_o, bclk_oe, lr_o, lr_oe, dw_o, dw_oe, sdo, modclk;
    logic       flag, gnd, settling, analog_sleep_in, digital_sleep_in, bclk_w, lr_w, dw_w;
    sac_word_t  left_w, right_w;
    int         errors      = 0;
    int         checks_done = 0;

    always #5 clk_sys = ~clk_sys;

    // Filter stand-in: one pair every 32 cycles
    always @(posedge clk_sys)
    begin
        lr_prev <= lr_w;
        m_prev  <= modclk;
        scnt    <= scnt + 5'h01;
        svalid  <= (scnt == 5'h00);
        spair   <= cur;
    end

    sac_core #(.CAL_PERIODS(CAL_P), .SETTLE_WORDS(SET_P)) u_sac_core (
        .CLK_SYS             (clk_sys),
        .ARST_N              (arst_n),
        .DIGITAL_SLEEP_IN    (dsleep),
        .ANALOG_SLEEP_IN     (asleep),
        .CLOCK_RATIO_SELECT  (ratio),
        .SERIAL_ROLE_SELECT  (role),
        .ZERO_INPUT_SELECT   (zero),
        .SAMPLE_PAIR         (spair),
        .SAMPLE_VALID        (svalid),
        .BIT_CLOCK_I         (bclk_w),
        .BIT_CLOCK_O         (bclk_o),
        .BIT_CLOCK_OE        (bclk_oe),
        .CHANNEL_STROBE_I    (lr_w),
        .CHANNEL_STROBE_O    (lr_o),
        .CHANNEL_STROBE_OE   (lr_oe),
        .DATA_WINDOW_I       (dw_w),
        .DATA_WINDOW_O       (dw_o),
        .DATA_WINDOW_OE      (dw_oe),
        .SERIAL_OUT_LINE     (sdo),
        .MODULATOR_CLOCK_OUT (modclk),
        .CALIBRATING_FLAG    (flag),
        .CAL_INPUT_GROUND    (gnd),
        .WORDS_SETTLING      (settling),
        .ANALOG_POWERDOWN    (analog_sleep_in),
        .DIGITAL_POWERDOWN   (digital_sleep_in)
    );

    sac_rx_model u_sac_rx_model (
        .clk_sys    (clk_sys),
        .role       (role),
        .ratio      (ratio),
        .win_gate   (gate),
        .bclk_o     (bclk_o),
        .bclk_oe    (bclk_oe),
        .lr_o       (lr_o),
        .lr_oe      (lr_oe),
        .dw_o       (dw_o),
        .dw_oe      (dw_oe),
        .sdo        (sdo),
        .bclk_w     (bclk_w),
        .lr_w       (lr_w),
        .dw_w       (dw_w),
        .left_word  (left_w),
        .right_word (right_w)
    );

    task automatic stop_test();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return flag;
            1: return lr_w;
            2: return dw_w;
            default: return settling;
        endcase
    endfunction

    task automatic wait_lvl(input int w, input logic v);
        for (int i = 0; i < 20000; i++)
        begin
            if (pick(w) === v)
                return;
            @(posedge clk_sys);
        end
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, ~v, v);
        stop_test();
    endtask

    // Strobe rises seen while the chosen signal stays high
    task automatic count_hi(input int w, output int n);
        n = 0;
        for (int i = 0; i < 20000 && pick(w) === 1'b1; i++)
        begin
            if (i > 0 && lr_w === 1'b1 && lr_prev === 1'b0)
                n++;
            @(posedge clk_sys);
        end
        // Master strobe rises on the edge that ends the phase
        if (lr_w === 1'b1 && lr_prev === 1'b0)
            n++;
    endtask

    task automatic span(input int w, input logic v, output int n);
        n = 0;
        while (pick(w) === v && n < 200)
        begin
            n++;
            @(posedge clk_sys);
        end
    endtask

    task automatic run_cal();
        int n;
        if (!role)
        begin
            wait_lvl(1, 1'b1);
            wait_lvl(1, 1'b0);
        end
        dsleep <= 1'b0;
        wait_lvl(0, 1'b1);
        check(36'(digital_sleep_in), 36'h0);
        check(36'(gnd), 36'(zero));
        count_hi(0, n);
        check(36'(n), 36'(CAL_P));
        cur <= DAT_PAIR;
        wait_lvl(3, 1'b1);
        count_hi(3, n);
        check(36'(n), 36'(SET_P));
    endtask

    initial
    begin
        sac_row_s  r;
        sac_word_t el;
        sac_word_t er;
        int        n;
        tick(4);
        check(36'(digital_sleep_in), 36'h1);
        check(36'(analog_sleep_in), 36'h1);
        check(36'(flag), 36'h0);
        check(36'(bclk_oe), 36'h0);
        tick(1);
        arst_n <= 1'b1;
        asleep <= 1'b0;
        tick(20);
        check(36'(analog_sleep_in), 36'h0);
        foreach (rows[i])
        begin
            r = rows[i];
            dsleep <= 1'b1;
            ratio  <= r.ra;
            role   <= r.ro;
            zero   <= r.ze;
            gate   <= r.ga;
            cur    <= CAL_PAIR;
            tick(6);
            check(36'(digital_sleep_in), 36'h1);
            run_cal();
            check(36'(lr_oe), 36'(r.ro));
            check(36'(bclk_oe), 36'(r.ro));
            n = 0;
            repeat (24)
            begin
                @(posedge clk_sys);
                if (modclk === 1'b1 && m_prev === 1'b0)
                    n++;
            end
            check(36'(n), 36'(r.mr));
            if (r.ro)
            begin
                wait_lvl(1, 1'b0);
                wait_lvl(1, 1'b1);
                span(2, 1'b0, n);
                check(36'(n), 36'(r.dl));
                span(2, 1'b1, n);
                check(36'(n), 36'(r.wc));
            end
            repeat (3)
            begin
                wait_lvl(1, 1'b0);
                wait_lvl(1, 1'b1);
            end
            el = DAT_PAIR.left - CAL_PAIR.left;
            er = DAT_PAIR.right - CAL_PAIR.right;
            if (!r.ga)
            begin
                el = {SAC_WORD_W{el[SAC_WORD_W-1]}};
                er = {SAC_WORD_W{er[SAC_WORD_W-1]}};
            end
            check(36'(left_w), 36'(el));
            check(36'(right_w), 36'(er));
        end
        // Sleep raised in mid-calibration, then a full restart
        dsleep <= 1'b1;
        gate   <= 1'b1;
        cur    <= CAL_PAIR;
        tick(6);
        dsleep <= 1'b0;
        wait_lvl(0, 1'b1);
        tick(40);
        dsleep <= 1'b1;
        tick(6);
        check(36'(flag), 36'h0);
        check(36'(digital_sleep_in), 36'h1);
        tick(4);
        run_cal();
        stop_test();
    end
endmodule
`default_nettype wire

// [verif/sac_rx_model.sv]
`default_nettype none
module sac_rx_model
    import sac_pkg::*;
#(
    parameter int unsigned BIT_HALF = 4
) (
    input  wire logic     clk_sys,
    input  wire logic     role,
    input  wire logic     ratio,
    input  wire logic     win_gate,
    input  wire logic     bclk_o,
    input  wire logic     bclk_oe,
    input  wire logic     lr_o,
    input  wire logic     lr_oe,
    input  wire logic     dw_o,
    input  wire logic     dw_oe,
    input  wire logic     sdo,
    output logic          bclk_w,
    output logic          lr_w,
    output logic          dw_w,
    output var sac_word_t left_word,
    output var sac_word_t right_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] div_q    = 8'h00;
    logic [4:0] bit_q    = 5'h00;
    logic [4:0] cnt_q    = 5'h00;
    logic       gbclk_q  = 1'b1;
    logic       glr_q    = 1'b1;
    logic       idle_q   = 1'b0;
    logic       bclk_p_q = 1'b0;
    logic       lr_p_q   = 1'b0;
    logic       skip_q   = 1'b0;
    logic       side_q   = 1'b0;
    sac_word_t  sh_q     = '0;
    logic       take;
    logic       wrap;

    // Released lines toggle so a stale level never reads as data
    assign bclk_w = bclk_oe ? bclk_o : (role ? idle_q : gbclk_q);
    assign lr_w   = lr_oe ? lr_o : (role ? idle_q : glr_q);
    assign dw_w   = dw_oe ? dw_o : (role ? idle_q : win_gate);
    // Master design: sample on rises, first one skipped; slave design: on falls
    assign take   = role ? (bclk_w & ~bclk_p_q) : (~bclk_w & bclk_p_q);
    // 64 bit clocks per strobe period at 512x or 384x master clock
    assign wrap   = (div_q == (ratio ? 8'(BIT_HALF * 3 / 4 - 1) : 8'(BIT_HALF - 1)));

    // Strobe turns on a bit-clock fall, 64 bit clocks per period
    always_ff @(posedge clk_sys)
    begin
        idle_q <= ~idle_q;
        div_q  <= wrap ? 8'h00 : div_q + 8'h01;
        if (wrap)
            gbclk_q <= ~gbclk_q;
        if (wrap && gbclk_q)
            bit_q <= bit_q + 5'h01;
        if (wrap && gbclk_q && bit_q == 5'h1F)
            glr_q <= ~glr_q;
    end

    always_ff @(posedge clk_sys)
    begin
        bclk_p_q <= bclk_w;
        lr_p_q   <= lr_w;
        if (lr_w != lr_p_q)
        begin
            cnt_q  <= 5'h00;
            skip_q <= role;
            side_q <= lr_w;
        end
        else if (take && skip_q)
            skip_q <= 1'b0;
        else if (take && cnt_q < 5'h12)
        begin
            sh_q  <= {sh_q[16:0], sdo};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h11 && side_q)
                left_word <= {sh_q[16:0], sdo};
            if (cnt_q == 5'h11 && !side_q)
                right_word <= {sh_q[16:0], sdo};
        end
    end
endmodule
`default_nettype wire
